/* core/strap_cfg_pkg.sv */
// Purpose: shared constants for the strap and power configuration block
// Assumes: one clock, straps read from the shared parallel pins
// Notes: strap bit positions are pin positions on the 24-bit data bus
`default_nettype none
package strap_cfg_pkg;
  localparam int DATA_W = 24;
  localparam int CTRL_W = 3;
  // strap positions on the shared data pins
  localparam int POS_CLK_SLEW = 21;
  localparam int POS_DATA_SLEW = 19;
  localparam int POS_SLEEP_SEL = 18;
  localparam int POS_STROBE = 17;
  localparam int POS_EQ_LO = 12;
  localparam int POS_OSC_LO = 8;
  localparam int POS_SPREAD_LO = 3;
  localparam int POS_MAP_LO = 0;
  localparam int EQ_W = 4;
  localparam int OSC_W = 3;
  localparam int SPREAD_W = 4;
  localparam int MAP_W = 2;
  // defaults after power down
  localparam logic [1:0] MAP_DEFAULT = 2'h0;
  localparam logic [3:0] EQ_DEFAULT = 4'h0;
  localparam logic [2:0] OSC_DEFAULT = 3'h0;
  localparam logic [3:0] SPREAD_DEFAULT = 4'h0;
  // field selects for host writes
  localparam logic [3:0] SEL_CLK_SLEW = 4'h0;
  localparam logic [3:0] SEL_DATA_SLEW = 4'h1;
  localparam logic [3:0] SEL_HOLD_LOW = 4'h2;
  localparam logic [3:0] SEL_SLEEP = 4'h3;
  localparam logic [3:0] SEL_STROBE = 4'h4;
  localparam logic [3:0] SEL_EQ = 4'h5;
  localparam logic [3:0] SEL_OSC = 4'h6;
  localparam logic [3:0] SEL_SPREAD = 4'h7;
  localparam logic [3:0] SEL_MAP = 4'h8;
  localparam logic [3:0] SEL_RELEASE = 4'h9;
  // number of clocks the pins are read as straps after power down ends
  localparam int STRAP_CYCLES = 2;
endpackage
`default_nettype wire

/* core/deser_strap_power_config.sv */
// Purpose: strap latch, host override and output gating of the deserializer configuration
// Assumes: power_down_input and all pins synchronous to clk; host writes one field per pulse
// Notes: slew, equalizer, oscillator, spread and map values drive analog or decode logic elsewhere
`default_nettype none

// What this block does
// - clock_output_slew_select at 1 asks for the fast clock edge rate, 0 is normal, and the host may set it.
// - data_output_slew_select at 1 asks for fast edges on all data and control outputs, and the host may set it.
// - with hold_outputs_low_option at 1 every output stays low, even when locked, until the host sets release.
// - with hold_outputs_low_option at 0 the outputs follow the link one clock after lock rises.
// - in power down the outputs take the state picked by sleep_output_state_select with the power-down input.
// - strobe_edge_select at 1 launches data for the rising clock edge, at 0 for the falling edge.
// - the four-bit equalization setting comes from straps or a host write.
// - the three-bit oscillator select comes from straps or a host write.
// - the four-bit spread range comes from straps or a host write.
// - the two-bit bit-mapping select comes from straps or a host write and defaults to zero.
// - power_down_input at 1 runs normally, at 0 powers down and clears every setting except sleep_output_state_select to default.
// - self_test_enable at 1 enters built-in self-test, at 0 runs normally.
// - the shared data pins are read as straps at power up before they are driven.
// - while lock is low the data, control and clock outputs take the sleep state, but stay driven low while hold-low is active.
module deser_strap_power_config
  import strap_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // power and mode pins
  input wire logic power_down_input,
  input wire logic self_test_enable,
  input wire logic link_locked,
  input wire logic hold_low_strap,
  // shared parallel pins
  input wire logic [DATA_W-1:0] data_pin_in,
  output logic [DATA_W-1:0] data_pin_out,
  output logic data_pin_oe,
  output logic [CTRL_W-1:0] control_out,
  output logic control_oe,
  output logic recovered_clock_output,
  output logic clock_oe,
  // recovered payload from the link
  input wire logic [DATA_W-1:0] link_data,
  input wire logic [CTRL_W-1:0] link_control,
  input wire logic link_clock_level,
  // host field writes
  input wire logic host_wr,
  input wire logic [3:0] host_sel,
  input wire logic [3:0] host_wdata,
  // settings out
  output logic clock_output_slew_select,
  output logic data_output_slew_select,
  output logic hold_outputs_low_option,
  output logic sleep_output_state_select,
  output logic strobe_edge_select,
  output logic [EQ_W-1:0] receive_equalization_setting,
  output logic [OSC_W-1:0] internal_oscillator_select,
  output logic [SPREAD_W-1:0] spread_range_select,
  output logic [MAP_W-1:0] bit_map_select,
  output logic hold_released,
  output logic self_test_active,
  output logic strapping
);

  typedef enum logic [1:0] {
    ST_DOWN = 2'b00,
    ST_STRAP = 2'b01,
    ST_RUN = 2'b10
  } phase_e;

  phase_e phase_q;
  logic [1:0] strap_cnt_q;
  logic wr_ok;
  logic strap_take;

  assign wr_ok = host_wr && (phase_q == ST_RUN);
  assign strap_take = (phase_q == ST_STRAP) && (strap_cnt_q == 2'(STRAP_CYCLES - 1));
  assign strapping = (phase_q != ST_RUN);

  // power phase: pins stay inputs for a few clocks so strap levels settle before sampling
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_q <= ST_DOWN;
      strap_cnt_q <= 2'h0;
    end
    else if (!power_down_input)
    begin
      phase_q <= ST_DOWN;
      strap_cnt_q <= 2'h0;
    end
    else
    begin
      unique case (phase_q)
        ST_DOWN:
        begin
          phase_q <= ST_STRAP;
          strap_cnt_q <= 2'h0;
        end
        ST_STRAP:
        begin
          strap_cnt_q <= strap_cnt_q + 2'h1;
          if (strap_take)
          begin
            phase_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          phase_q <= ST_RUN;
        end
        default:
        begin
          phase_q <= ST_DOWN;
        end
      endcase
    end
  end

  // settings: cleared in power down except the sleep select, strap latched on wake, host write overrides after
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clock_output_slew_select <= 1'b0;
      data_output_slew_select <= 1'b0;
      hold_outputs_low_option <= 1'b0;
      sleep_output_state_select <= 1'b0;
      strobe_edge_select <= 1'b0;
      receive_equalization_setting <= EQ_DEFAULT;
      internal_oscillator_select <= OSC_DEFAULT;
      spread_range_select <= SPREAD_DEFAULT;
      bit_map_select <= MAP_DEFAULT;
      hold_released <= 1'b0;
    end
    else if (!power_down_input)
    begin
      clock_output_slew_select <= 1'b0;
      data_output_slew_select <= 1'b0;
      hold_outputs_low_option <= 1'b0;
      strobe_edge_select <= 1'b0;
      receive_equalization_setting <= EQ_DEFAULT;
      internal_oscillator_select <= OSC_DEFAULT;
      spread_range_select <= SPREAD_DEFAULT;
      bit_map_select <= MAP_DEFAULT;
      hold_released <= 1'b0;
      // the sleep select keeps its value, it decides the pin state in power down
      sleep_output_state_select <= sleep_output_state_select;
    end
    else if (strap_take)
    begin
      clock_output_slew_select <= data_pin_in[POS_CLK_SLEW];
      data_output_slew_select <= data_pin_in[POS_DATA_SLEW];
      hold_outputs_low_option <= hold_low_strap;
      // the sleep strap is meaningless when the board asks for hold-low
      sleep_output_state_select <= hold_low_strap ? 1'b0 : data_pin_in[POS_SLEEP_SEL];
      strobe_edge_select <= data_pin_in[POS_STROBE];
      receive_equalization_setting <= data_pin_in[POS_EQ_LO +: EQ_W];
      internal_oscillator_select <= data_pin_in[POS_OSC_LO +: OSC_W];
      spread_range_select <= data_pin_in[POS_SPREAD_LO +: SPREAD_W];
      bit_map_select <= data_pin_in[POS_MAP_LO +: MAP_W];
    end
    else if (wr_ok)
    begin
      unique case (host_sel)
        SEL_CLK_SLEW: clock_output_slew_select <= host_wdata[0];
        SEL_DATA_SLEW: data_output_slew_select <= host_wdata[0];
        SEL_HOLD_LOW: hold_outputs_low_option <= host_wdata[0];
        SEL_SLEEP: sleep_output_state_select <= host_wdata[0];
        SEL_STROBE: strobe_edge_select <= host_wdata[0];
        SEL_EQ: receive_equalization_setting <= host_wdata[EQ_W-1:0];
        SEL_OSC: internal_oscillator_select <= host_wdata[OSC_W-1:0];
        SEL_SPREAD: spread_range_select <= host_wdata[SPREAD_W-1:0];
        SEL_MAP: bit_map_select <= host_wdata[MAP_W-1:0];
        SEL_RELEASE: hold_released <= host_wdata[0];
        default: hold_released <= hold_released;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      self_test_active <= 1'b0;
    end
    else
    begin
      self_test_active <= self_test_enable && power_down_input && (phase_q == ST_RUN);
    end
  end

  // output stage; the strobe edge is realised by the launch edge of the clock output
  logic hold_low;
  logic sleep_state;
  logic run;
  logic park_drive;
  assign run = (phase_q == ST_RUN);
  assign hold_low = hold_outputs_low_option && !hold_released;
  // sleep select 0 floats the pins, 1 drives them low
  assign sleep_state = !power_down_input || !link_locked;
  // pins float while straps are read; in power down only the sleep select decides whether they are driven
  assign park_drive = (run && hold_low) || (sleep_output_state_select && (run || !power_down_input));

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_pin_out <= '0;
      control_out <= '0;
      recovered_clock_output <= 1'b0;
      data_pin_oe <= 1'b0;
      control_oe <= 1'b0;
      clock_oe <= 1'b0;
    end
    else if (!run || sleep_state || hold_low)
    begin
      data_pin_out <= '0;
      control_out <= '0;
      recovered_clock_output <= 1'b0;
      data_pin_oe <= park_drive;
      control_oe <= park_drive;
      clock_oe <= park_drive;
    end
    else
    begin
      data_pin_out <= link_data;
      control_out <= link_control;
      recovered_clock_output <= strobe_edge_select ? link_clock_level : !link_clock_level;
      data_pin_oe <= 1'b1;
      control_oe <= 1'b1;
      clock_oe <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* verif/strap_cfg_checker_assertions.sv */
// Purpose: port-level checks of the strap and power configuration block
// Assumes: one clock, rst_b asynchronous active low
// Notes: write checks only count writes taken in the run phase
`default_nettype none
module strap_cfg_checker
  import strap_cfg_pkg::*;
(
  // clock, reset and inputs
  input wire logic clk,
  input wire logic rst_b,
  input wire logic power_down_input,
  input wire logic link_locked,
  input wire logic host_wr,
  input wire logic [3:0] host_sel,
  input wire logic [3:0] host_wdata,
  input wire logic [DATA_W-1:0] link_data,
  // outputs watched
  input wire logic [DATA_W-1:0] data_pin_out,
  input wire logic data_pin_oe,
  input wire logic [CTRL_W-1:0] control_out,
  input wire logic strapping,
  input wire logic hold_outputs_low_option,
  input wire logic hold_released,
  input wire logic sleep_output_state_select,
  input wire logic [EQ_W-1:0] receive_equalization_setting,
  input wire logic [OSC_W-1:0] internal_oscillator_select,
  input wire logic [SPREAD_W-1:0] spread_range_select,
  input wire logic [MAP_W-1:0] bit_map_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire logic wr_ok = host_wr && !strapping && power_down_input;
  AST_PD_CLEAR: assert property (!power_down_input |=>
    receive_equalization_setting == EQ_DEFAULT && bit_map_select == MAP_DEFAULT) else $error("settings kept");
  AST_WR_EQ: assert property (wr_ok && host_sel == SEL_EQ |=>
    receive_equalization_setting == $past(host_wdata)) else $error("eq write lost");
  AST_WR_OSC: assert property (wr_ok && host_sel == SEL_OSC |=>
    internal_oscillator_select == 3'($past(host_wdata))) else $error("osc write lost");
  AST_WR_SPREAD: assert property (wr_ok && host_sel == SEL_SPREAD |=>
    spread_range_select == $past(host_wdata)) else $error("spread write lost");
  AST_WR_MAP: assert property (wr_ok && host_sel == SEL_MAP |=>
    bit_map_select == 2'($past(host_wdata))) else $error("map write lost");
  AST_UNLOCKED: assert property (!link_locked && !sleep_output_state_select && !hold_outputs_low_option |=>
    !data_pin_oe) else $error("pins driven while unlocked");
  AST_RUN_PASS: assert property (link_locked && power_down_input && !strapping && !hold_outputs_low_option |=>
    data_pin_oe && data_pin_out == $past(link_data)) else $error("payload not passed");
  AST_HOLD: assert property (hold_outputs_low_option && !hold_released |=>
    data_pin_out == '0 && control_out == '0) else $error("held outputs moved");
  AST_SLEEP_DRIVE: assert property (!power_down_input && sleep_output_state_select |=>
    data_pin_oe && data_pin_out == '0) else $error("sleep state not driven low");
  AST_STRAP_FLOAT: assert property (strapping && power_down_input |=>
    !data_pin_oe) else $error("pins driven while straps are read");
  cover property (wr_ok && host_sel == SEL_EQ);
  cover property (hold_outputs_low_option && hold_released);
  cover property ($fell(power_down_input));
  cover property (!power_down_input && sleep_output_state_select);
endmodule
bind deser_strap_power_config strap_cfg_checker i_chk (.*);
`default_nettype wire

/* verif/strap_board_model.sv */
// Purpose: board strap resistors on the shared parallel pins
// Assumes: a strap reads only while the device leaves the pin undriven
// Notes: driven pins read back the device's own level
`default_nettype none
module strap_board_model
  import strap_cfg_pkg::*;
(
  // strap pattern and pin side
  input wire logic [DATA_W-1:0] straps,
  input wire logic [DATA_W-1:0] data_pin_out,
  input wire logic data_pin_oe,
  output logic [DATA_W-1:0] data_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign data_pin_in = data_pin_oe ? data_pin_out : straps;
endmodule
`default_nettype wire

/* verif/deser_strap_power_config_tb.sv */
// Purpose: self-checking bench of the strap and power configuration block
// Assumes: inputs change on the falling edge
// Notes: strap pattern sets every field except the sleep select to a non-default value
`default_nettype none
`define CHK(n, e, s) chk(n, 24'(e), 24'(s))
module deser_strap_power_config_tb
  import strap_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, pd = 1'b0, ste = 1'b0, lock = 1'b1, hold = 1'b0, wr = 1'b0, lclk = 1'b1;
  logic [3:0] sel = 4'h0, wd = 4'h0, eq, spr;
  logic [DATA_W-1:0] straps = 24'h2aa54a, ldat = 24'h5a5a5a, pin_in, pin_out;
  logic [CTRL_W-1:0] lctl = 3'h5, cout;
  logic [2:0] osc;
  logic [1:0] map;
  logic oe, coe, rco, cko, cks, dts, hol, sls, stb, hrel, sta, strp;
  int failures = 0, comparisons = 0;
  always #50 clk = ~clk;
  deser_strap_power_config i_dut (.clk(clk), .rst_b(rst_b), .power_down_input(pd), .self_test_enable(ste),
    .link_locked(lock), .hold_low_strap(hold), .data_pin_in(pin_in), .data_pin_out(pin_out), .data_pin_oe(oe),
    .control_out(cout), .control_oe(coe), .recovered_clock_output(rco), .clock_oe(cko), .link_data(ldat),
    .link_control(lctl), .link_clock_level(lclk), .host_wr(wr), .host_sel(sel), .host_wdata(wd),
    .clock_output_slew_select(cks), .data_output_slew_select(dts), .hold_outputs_low_option(hol),
    .sleep_output_state_select(sls), .strobe_edge_select(stb), .receive_equalization_setting(eq),
    .internal_oscillator_select(osc), .spread_range_select(spr), .bit_map_select(map),
    .hold_released(hrel), .self_test_active(sta), .strapping(strp));
  strap_board_model i_board (.straps(straps), .data_pin_out(pin_out), .data_pin_oe(oe), .data_pin_in(pin_in));
  task chk(input string n, input logic [23:0] e, input logic [23:0] s);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // callers end a burst with stop so back-to-back writes never touch wr twice in one step
  task put(input logic [3:0] s, input logic [3:0] d);
    @(negedge clk);
    wr = 1;
    sel = s;
    wd = d;
  endtask
  task stop;
    @(negedge clk);
    wr = 0;
    @(negedge clk);
  endtask
  task power_cycle;
    @(negedge clk);
    pd = 0;
    repeat (3) @(negedge clk);
    pd = 1;
    for (int i = 0; i < 10 && strp !== 1'b0; i++) @(negedge clk);
  endtask
  task t_straps;
    power_cycle;
    `CHK("eq", straps[POS_EQ_LO +: EQ_W], eq);
    `CHK("osc", straps[POS_OSC_LO +: OSC_W], osc);
    `CHK("spread", straps[POS_SPREAD_LO +: SPREAD_W], spr);
    `CHK("map", straps[POS_MAP_LO +: MAP_W], map);
    `CHK("clk slew", straps[POS_CLK_SLEW], cks);
    `CHK("data slew", straps[POS_DATA_SLEW], dts);
    `CHK("strobe", straps[POS_STROBE], stb);
    `CHK("sleep", straps[POS_SLEEP_SEL], sls);
    repeat (2) @(negedge clk);
    `CHK("pins", ldat, pin_out);
    `CHK("ctrl", 3'h5, cout);
    `CHK("ctrl oe", 1'b1, coe);
    `CHK("clock oe", 1'b1, cko);
    `CHK("clock out", 1'b1, rco);
    $display("t_straps done");
  endtask
  task t_writes;
    put(SEL_EQ, 4'h3);
    put(SEL_OSC, 4'he);
    put(SEL_SPREAD, 4'hc);
    put(SEL_MAP, 4'h5);
    put(SEL_CLK_SLEW, 4'h0);
    put(SEL_STROBE, 4'h0);
    put(4'hf, 4'hf);
    stop;
    `CHK("eq", 4'h3, eq);
    `CHK("osc", 3'h6, osc);
    `CHK("spread", 4'hc, spr);
    `CHK("map", 2'h1, map);
    `CHK("clk slew", 1'b0, cks);
    `CHK("clock out", 1'b0, rco);
    `CHK("data slew", 1'b1, dts);
    lclk = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("clock out low level", 1'b1, rco);
    $display("t_writes done");
  endtask
  task t_power_down;
    put(SEL_SLEEP, 4'h1);
    put(SEL_DATA_SLEW, 4'h0);
    stop;
    `CHK("data slew", 1'b0, dts);
    pd = 1'b0;
    repeat (2) @(negedge clk);
    put(SEL_EQ, 4'h7);
    stop;
    `CHK("eq", EQ_DEFAULT, eq);
    `CHK("map", MAP_DEFAULT, map);
    `CHK("sleep kept", 1'b1, sls);
    `CHK("sleep oe", 1'b1, oe);
    `CHK("sleep ctrl oe", 1'b1, coe);
    `CHK("sleep clock oe", 1'b1, cko);
    `CHK("sleep pins", 24'h0, pin_out);
    $display("t_power_down done");
  endtask
  task t_hold;
    hold = 1'b1;
    straps = '0;
    power_cycle;
    repeat (2) @(negedge clk);
    `CHK("hold", 1'b1, hol);
    `CHK("held pins", 24'h0, pin_out);
    `CHK("held oe", 1'b1, oe);
    put(SEL_RELEASE, 4'h1);
    stop;
    `CHK("released", 1'b1, hrel);
    `CHK("pins", ldat, pin_out);
    lock = 1'b0;
    ste = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("unlocked oe", 1'b0, oe);
    `CHK("self test", 1'b1, sta);
    ste = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("self test", 1'b0, sta);
    pd = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("floating sleep oe", 1'b0, oe);
    `CHK("hold cleared", 1'b0, hol);
    $display("t_hold done");
  endtask
  task close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst_b = 1;
    t_straps;
    t_writes;
    t_power_down;
    t_hold;
    close_out;
  end
  // the scenarios need about 60 clocks; the limit leaves ample margin
  initial
  begin
    repeat (2000) @(posedge clk);
    failures++;
    close_out;
  end
endmodule
`default_nettype wire
